// >>> design/pbm_manager.sv
// Local design decision: register access over APB.
`timescale 1ns/1ps

// Notes on behaviour
// [RULE1] Command 000 does nothing.
// [RULE2] Allocate reserves requested pages, ten at most.
// [RULE3] Page field is total minus one.
// [RULE4] Allocate sets failed flag, clears when done.
// [RULE5] Short allocation resumes after each release.
// [RULE6] Firmware never overlaps allocate commands.
// [RULE7] Command 010 resets pages, queues, events.
// [RULE8] Command 011 pops receive queue head.
// [RULE9] Remove-and-release also frees head's pages.
// [RULE10] Command 101 frees selected packet's pages.
// [RULE11] Command 110 enqueues selected packet to endpoint.
// [RULE12] Firmware loads endpoint select before commands.
// [RULE13] Endpoint select low four bits choose endpoint.
// [RULE14] Command 111 empties endpoint queue, frees nothing.
// [RULE15] Allocation result shows packet number bits 4:0.
// [RULE16] Packet selector picks buffer window packet.
// [RULE17] NAK-all bit blocks OUT and DMA allocation.
// [RULE18] Free count live, resets to 0x20.
// [RULE19] Completion FIFO 32 deep, empty/full flags.
// [RULE20] Firmware drains completion FIFO before full.
// [RULE21] Received packet numbers enter receive queue.
// [RULE22] Receive queue shows empty and full flags.
// [RULE23] Only complete, token-clean packets are queued.
// [RULE24] Completion read pops; receive read peeks.
module pbm_manager (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RESETN,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [17:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Serial-engine DMA side.
  input wire pbm_pkg::pbm_dma_s DMA_IN,
  output logic ALLOCATION_DONE_INTERRUPT_GRANT,
  output logic [4:0] ALLOCATION_DONE_INTERRUPT_PKT,
  output logic NAK_RECEIVE,
  output logic RX_OVERFLOW,
  output logic [4:0] WINDOW_PKT,
  output logic ALLOCATION_DONE_INTERRUPT_DONE
);
  import pbm_pkg::*;

  // ----------------------------------------------------------------------
  // Storage.
  // ----------------------------------------------------------------------
  logic [NUM_PAGES-1:0] page_used_r;
  logic [NUM_PAGES-1:0] page_owned [NUM_PAGES];
  logic [4:0] page_free_r;
  logic [5:0] free_cnt;
  logic [7:0] allocation_done_interrupt_result_r;
  logic [4:0] pkt_sel_r;
  logic [3:0] ep_sel_r;
  logic nak_all_r;
  pbm_allocation_done_interrupt_e al_state_r;
  logic [3:0] al_need_r;
  logic [4:0] cq_mem [CQ_DEPTH];
  logic [5:0] cq_wp_r, cq_rp_r;
  logic [4:0] rq_mem [RXQ_DEPTH];
  logic [5:0] rq_wp_r, rq_rp_r;
  logic [4:0] tq_mem [NUM_ENDPOINTS][TXQ_DEPTH];
  logic [2:0] tq_cnt_r [NUM_ENDPOINTS];
  logic [2:0] tq_rp_r [NUM_ENDPOINTS];

  // Count ones in a page map.
  function automatic logic [5:0] ones(input logic [NUM_PAGES-1:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < NUM_PAGES; i++) begin
      n = n + {5'h00, v[i]};
    end
    return n;
  endfunction : ones

  // ----------------------------------------------------------------------
  // APB decode.
  // ----------------------------------------------------------------------
  // Each register takes one aligned word; the word address is the index.
  logic wr_acc, rd_acc, hit, aligned;
  logic [15:0] ridx;
  pbm_cmd_e cmd;
  assign aligned = PADDR[1:0] == 2'b00;
  assign ridx = PADDR[17:2];
  assign wr_acc = PSEL && PENABLE && PWRITE && aligned;
  assign rd_acc = PSEL && PENABLE && !PWRITE && aligned;
  assign hit = aligned && ridx inside {IDX_ENDPOINT_SELECT, IDX_COMMAND,
    IDX_ALLOCATION_DONE_INTERRUPT_RESULT, IDX_PACKET_SELECTOR, IDX_FREE_PAGE_COUNT,
    IDX_TX_COMPLETION, IDX_RX_PACKET_QUEUE};
  assign cmd = pbm_cmd_e'(PWDATA[CMD_CODE_LSB +: 3]);

  // A command is one write to the command register.
  logic cmd_v;
  assign cmd_v = wr_acc && ridx == IDX_COMMAND;
  // [RULE1] Noop falls out.
  logic do_reset, do_allocation_done_interrupt, do_pop, do_popfree, do_rel, do_enq, do_txr;
  assign do_reset = cmd_v && cmd == CMD_RESET;
  assign do_allocation_done_interrupt = cmd_v && cmd == CMD_ALLOCATE;
  assign do_pop = cmd_v && (cmd == CMD_REMOVE || cmd == CMD_REMOVE_RELEASE);
  assign do_popfree = cmd_v && cmd == CMD_REMOVE_RELEASE;
  assign do_rel = cmd_v && cmd == CMD_RELEASE;
  assign do_enq = cmd_v && cmd == CMD_ENQUEUE;
  assign do_txr = cmd_v && cmd == CMD_TX_RESET;

  logic rq_empty, rq_full, cq_empty, cq_full;
  assign rq_empty = rq_wp_r == rq_rp_r;
  assign rq_full = rq_wp_r == {~rq_rp_r[5], rq_rp_r[4:0]};
  assign cq_empty = cq_wp_r == cq_rp_r;
  assign cq_full = cq_wp_r == {~cq_rp_r[5], cq_rp_r[4:0]};

  // ----------------------------------------------------------------------
  // Page release selection.
  // ----------------------------------------------------------------------
  // [RULE9] Free queue head.
  logic rel_cmd;
  logic [4:0] rel_pkt;
  assign rel_cmd = do_rel || (do_popfree && !rq_empty);
  // [RULE10] Free selected packet.
  assign rel_pkt = do_rel ? pkt_sel_r : rq_mem[rq_rp_r[4:0]];
  logic [NUM_PAGES-1:0] rel_mask;
  always_comb begin
    rel_mask = '0;
    if (rel_cmd) begin
      rel_mask = rel_mask | page_owned[rel_pkt];
    end
    if (DMA_IN.release_req) begin
      rel_mask = rel_mask | page_owned[DMA_IN.release_pkt];
    end
  end

  // ----------------------------------------------------------------------
  // Allocation: firmware command waits, else serial-engine DMA request.
  // ----------------------------------------------------------------------
  // [RULE17] No DMA allocation while NAK-all.
  logic dma_allocation_done_interrupt;
  logic [3:0] need;
  assign dma_allocation_done_interrupt = DMA_IN.allocation_done_interrupt_req && !nak_all_r && al_state_r == AL_IDLE
    && !do_allocation_done_interrupt && DMA_IN.allocation_done_interrupt_pages <= MAX_PAGE_FIELD
    && !ALLOCATION_DONE_INTERRUPT_GRANT; // The grant cycle closes the held request.
  // [RULE3] Field plus one pages.
  assign need = al_state_r == AL_PENDING ? al_need_r : DMA_IN.allocation_done_interrupt_pages;
  assign free_cnt = ones(~page_used_r);
  logic try_allocation_done_interrupt, can_allocation_done_interrupt;
  assign try_allocation_done_interrupt = al_state_r == AL_PENDING || dma_allocation_done_interrupt;
  // [RULE5] Retries each cycle, succeeds once releases suffice.
  assign can_allocation_done_interrupt = try_allocation_done_interrupt && !do_reset
    && free_cnt > {2'b00, need} && ones(page_owned[page_free_r]) == 6'h00;

  // Grab the lowest free pages for a packet.
  logic [NUM_PAGES-1:0] grab;
  always_comb begin
    logic [4:0] left;
    left = {1'b0, need} + 5'h01;
    grab = '0;
    for (int i = 0; i < NUM_PAGES; i++) begin
      if (!page_used_r[i] && left != 5'h00) begin
        grab[i] = 1'b1;
        left = left - 5'h01;
      end
    end
  end

  // [RULE2] Reserve pages under packet number.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      page_used_r <= '0;
      for (int p = 0; p < NUM_PAGES; p++) begin
        page_owned[p] <= '0;
      end
    end else if (do_reset) begin
      // [RULE7] Free every page.
      page_used_r <= '0;
      for (int p = 0; p < NUM_PAGES; p++) begin
        page_owned[p] <= '0;
      end
    end else begin
      page_used_r <= (page_used_r & ~rel_mask) | (can_allocation_done_interrupt ? grab : '0);
      for (int p = 0; p < NUM_PAGES; p++) begin
        page_owned[p] <= page_owned[p] & ~rel_mask;
      end
      if (can_allocation_done_interrupt) begin
        page_owned[page_free_r] <= grab;
      end
    end
  end

  // Packet numbers rotate; a number is usable when it owns no pages.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      page_free_r <= 5'h00;
    end else if (do_reset) begin
      page_free_r <= 5'h00;
    end else if (try_allocation_done_interrupt && !can_allocation_done_interrupt) begin
      page_free_r <= page_free_r + 5'h01;
    end else if (can_allocation_done_interrupt) begin
      page_free_r <= page_free_r + 5'h01;
    end
  end

  // [RULE4] Failed flag across allocate.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      al_state_r <= AL_IDLE;
      al_need_r <= 4'h0;
      allocation_done_interrupt_result_r <= 8'h00;
      ALLOCATION_DONE_INTERRUPT_DONE <= 1'b0;
    end else if (do_reset) begin
      al_state_r <= AL_IDLE;
      allocation_done_interrupt_result_r <= 8'h00;
      ALLOCATION_DONE_INTERRUPT_DONE <= 1'b0;
    end else begin
      ALLOCATION_DONE_INTERRUPT_DONE <= 1'b0;
      case (al_state_r)
        AL_IDLE: begin
          if (do_allocation_done_interrupt && PWDATA[3:0] <= MAX_PAGE_FIELD) begin
            al_state_r <= AL_PENDING;
            al_need_r <= PWDATA[3:0];
            allocation_done_interrupt_result_r[FAILED_BIT] <= 1'b1;
          end
        end
        AL_PENDING: begin
          if (can_allocation_done_interrupt) begin
            al_state_r <= AL_IDLE;
            // [RULE15] Packet number result.
            allocation_done_interrupt_result_r <= {3'b000, page_free_r};
            ALLOCATION_DONE_INTERRUPT_DONE <= 1'b1;
          end
        end
        default: al_state_r <= AL_IDLE;
      endcase
    end
  end

  // DMA allocation answer.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      ALLOCATION_DONE_INTERRUPT_GRANT <= 1'b0;
      ALLOCATION_DONE_INTERRUPT_PKT <= 5'h00;
    end else begin
      ALLOCATION_DONE_INTERRUPT_GRANT <= can_allocation_done_interrupt && al_state_r == AL_IDLE;
      ALLOCATION_DONE_INTERRUPT_PKT <= page_free_r;
    end
  end

  // ----------------------------------------------------------------------
  // Software registers.
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      pkt_sel_r <= 5'h00;
      ep_sel_r <= 4'h0;
      nak_all_r <= 1'b0;
    end else if (wr_acc) begin
      // [RULE16] Selector write.
      if (ridx == IDX_PACKET_SELECTOR) pkt_sel_r <= PWDATA[4:0];
      // [RULE13] Endpoint select.
      if (ridx == IDX_ENDPOINT_SELECT) ep_sel_r <= PWDATA[3:0];
      if (ridx == IDX_FREE_PAGE_COUNT) nak_all_r <= PWDATA[NAK_ALL_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Receive queue.
  // ----------------------------------------------------------------------
  // [RULE23] Complete packets only.
  logic rq_push;
  assign rq_push = DMA_IN.rx_done && DMA_IN.rx_header_ok
    && DMA_IN.rx_token_ok && !rq_full;
  // [RULE21] Push packet number.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      rq_wp_r <= 6'h00;
      rq_rp_r <= 6'h00;
    end else if (do_reset) begin
      rq_wp_r <= 6'h00;
      rq_rp_r <= 6'h00;
    end else begin
      if (rq_push) begin
        rq_mem[rq_wp_r[4:0]] <= DMA_IN.rx_pkt;
        rq_wp_r <= rq_wp_r + 6'h01;
      end
      // [RULE8] Pop head only.
      if (do_pop && !rq_empty) rq_rp_r <= rq_rp_r + 6'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Completion queue.
  // ----------------------------------------------------------------------
  logic cq_pop;
  assign cq_pop = rd_acc && ridx == IDX_TX_COMPLETION && !cq_empty;
  // [RULE19] Completion push.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      cq_wp_r <= 6'h00;
      cq_rp_r <= 6'h00;
    end else if (do_reset) begin
      cq_wp_r <= 6'h00;
      cq_rp_r <= 6'h00;
    end else begin
      if (DMA_IN.tx_done && !cq_full) begin
        cq_mem[cq_wp_r[4:0]] <= DMA_IN.tx_pkt;
        cq_wp_r <= cq_wp_r + 6'h01;
      end
      // [RULE24] Read pops.
      if (cq_pop) cq_rp_r <= cq_rp_r + 6'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Per-endpoint transmit queues.
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int e = 0; e < NUM_ENDPOINTS; e++) begin
        tq_cnt_r[e] <= 3'h0;
        tq_rp_r[e] <= 3'h0;
      end
    end else if (do_reset) begin
      for (int e = 0; e < NUM_ENDPOINTS; e++) begin
        tq_cnt_r[e] <= 3'h0;
        tq_rp_r[e] <= 3'h0;
      end
    end else begin
      for (int e = 0; e < NUM_ENDPOINTS; e++) begin
        logic push, pop;
        logic [2:0] wi;
        push = do_enq && ep_sel_r == 4'(e) && tq_cnt_r[e] < 3'(TXQ_DEPTH);
        pop = DMA_IN.tx_pop && DMA_IN.tx_pop_ep == 4'(e)
          && tq_cnt_r[e] != 3'h0;
        wi = 3'((tq_rp_r[e] + tq_cnt_r[e]) % TXQ_DEPTH);
        // [RULE11] Enqueue selected packet.
        if (push) tq_mem[e][wi] <= pkt_sel_r;
        if (pop) tq_rp_r[e] <= 3'((tq_rp_r[e] + 3'h1) % TXQ_DEPTH);
        tq_cnt_r[e] <= tq_cnt_r[e] + 3'(push) - 3'(pop);
        // [RULE14] Empty queue, keep pages.
        if (do_txr && ep_sel_r == 4'(e)) begin
          tq_cnt_r[e] <= 3'h0;
          tq_rp_r[e] <= 3'h0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Status outputs and APB answer (zero wait, error on unmapped).
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      NAK_RECEIVE <= 1'b0;
      RX_OVERFLOW <= 1'b0;
      WINDOW_PKT <= 5'h00;
    end else begin
      // [RULE17] NAK OUT and bulk.
      NAK_RECEIVE <= nak_all_r;
      // [RULE22] Full refuses packets.
      RX_OVERFLOW <= rq_full;
      WINDOW_PKT <= pkt_sel_r;
    end
  end

  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit;

  // Read mux.
  always_comb begin
    PRDATA = 32'h0000_0000;
    if (rd_acc) begin
      case (ridx)
        IDX_ENDPOINT_SELECT: PRDATA = {28'h0, ep_sel_r};
        IDX_ALLOCATION_DONE_INTERRUPT_RESULT: PRDATA = {24'h0, allocation_done_interrupt_result_r};
        IDX_PACKET_SELECTOR: PRDATA = {27'h0, pkt_sel_r};
        // [RULE18] Live free count.
        IDX_FREE_PAGE_COUNT: PRDATA = {24'h0, nak_all_r, 1'b0, free_cnt};
        IDX_TX_COMPLETION: PRDATA = {24'h0, cq_empty, cq_full, 1'b0,
          cq_empty ? 5'h00 : cq_mem[cq_rp_r[4:0]]};
        // [RULE24] Peek receive head.
        IDX_RX_PACKET_QUEUE: PRDATA = {24'h0, rq_empty, rq_full, 1'b0,
          rq_empty ? 5'h00 : rq_mem[rq_rp_r[4:0]]};
        default: PRDATA = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  AST_ALLOCATION_DONE_INTERRUPT_FAILS: assert property ( // [RULE4]
    do_allocation_done_interrupt && al_state_r == AL_IDLE && PWDATA[3:0] <= MAX_PAGE_FIELD
    |=> allocation_done_interrupt_result_r[FAILED_BIT])
    else $error("failed flag not set by allocate");
  AST_DONE_CLEARS: assert property ( // [RULE4]
    ALLOCATION_DONE_INTERRUPT_DONE |-> !allocation_done_interrupt_result_r[FAILED_BIT]
    && $past(al_state_r) == AL_PENDING)
    else $error("allocation done with failed flag");
  AST_RESET_FREES: assert property ( // [RULE7]
    do_reset |=> free_cnt == 6'h20 && rq_empty && cq_empty)
    else $error("reset command left state");
  AST_POP_ONE: assert property ( // [RULE8]
    do_pop && !rq_empty && !rq_push
    |=> rq_rp_r == $past(rq_rp_r) + 6'h01)
    else $error("receive pop wrong");
  AST_NAK_BLOCK: assert property ( // [RULE17]
    nak_all_r |=> !ALLOCATION_DONE_INTERRUPT_GRANT)
    else $error("allocation while NAK-all");
  AST_CQ_POP: assert property ( // [RULE24]
    cq_pop && !DMA_IN.tx_done
    |=> cq_rp_r == $past(cq_rp_r) + 6'h01)
    else $error("completion read did not pop");
  AST_TXR_EMPTY: assert property ( // [RULE14]
    do_txr |=> tq_cnt_r[$past(ep_sel_r)] == 3'h0)
    else $error("endpoint queue not emptied");
  AST_ENQ_PUSH: assert property ( // [RULE11]
    do_enq && tq_cnt_r[ep_sel_r] < 3'(TXQ_DEPTH) && !DMA_IN.tx_pop
    |=> tq_cnt_r[$past(ep_sel_r)] == $past(tq_cnt_r[ep_sel_r]) + 3'h1)
    else $error("enqueue did not grow endpoint queue");
  AST_BAD_RX: assert property ( // [RULE23]
    DMA_IN.rx_done && !DMA_IN.rx_header_ok && !do_reset
    |=> rq_wp_r == $past(rq_wp_r))
    else $error("incomplete packet queued");

endmodule : pbm_manager

// >>> design/pbm_pkg.sv
package pbm_pkg;

  // ----------------------------------------------------------------------
  // Register indices; each register is one word at four times its index.
  // ----------------------------------------------------------------------
  localparam logic [15:0] IDX_ENDPOINT_SELECT = 16'h7F52;
  localparam logic [15:0] IDX_COMMAND = 16'h7F53;
  localparam logic [15:0] IDX_ALLOCATION_DONE_INTERRUPT_RESULT = 16'h7F54;
  localparam logic [15:0] IDX_PACKET_SELECTOR = 16'h7F55;
  localparam logic [15:0] IDX_FREE_PAGE_COUNT = 16'h7F56;
  localparam logic [15:0] IDX_TX_COMPLETION = 16'h7F57;
  localparam logic [15:0] IDX_RX_PACKET_QUEUE = 16'h7F58;

  // ----------------------------------------------------------------------
  // Field positions and reset values.
  // ----------------------------------------------------------------------
  localparam int CMD_CODE_LSB = 5;
  localparam int FAILED_BIT = 7;
  localparam int NAK_ALL_BIT = 7;
  localparam int EMPTY_BIT = 7;
  localparam int FULL_BIT = 6;
  localparam logic [5:0] FREE_PAGES_RESET = 6'h20;
  localparam logic [7:0] TX_COMPLETION_RESET = 8'h80;
  localparam logic [3:0] MAX_PAGE_FIELD = 4'h9;
  localparam int NUM_PAGES = 32;
  localparam int NUM_ENDPOINTS = 16;
  localparam int TXQ_DEPTH = 5;
  localparam int CQ_DEPTH = 32;
  localparam int RXQ_DEPTH = 32;

  // ----------------------------------------------------------------------
  // Command codes.
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NOOP = 3'b000,
    CMD_ALLOCATE = 3'b001,
    CMD_RESET = 3'b010,
    CMD_REMOVE = 3'b011,
    CMD_REMOVE_RELEASE = 3'b100,
    CMD_RELEASE = 3'b101,
    CMD_ENQUEUE = 3'b110,
    CMD_TX_RESET = 3'b111
  } pbm_cmd_e;

  // Allocator states.
  typedef enum logic [0:0] {
    AL_IDLE = 1'b0,
    AL_PENDING = 1'b1
  } pbm_allocation_done_interrupt_e;

  // Serial-engine DMA requests travel together.
  typedef struct packed {
    logic allocation_done_interrupt_req;
    logic [3:0] allocation_done_interrupt_pages;
    logic release_req;
    logic [4:0] release_pkt;
    logic rx_done;
    logic rx_header_ok;
    logic rx_token_ok;
    logic [4:0] rx_pkt;
    logic tx_done;
    logic [4:0] tx_pkt;
    logic [3:0] tx_pop_ep;
    logic tx_pop;
  } pbm_dma_s;

endpackage : pbm_pkg

// >>> tb/pbm_dma_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Serial-engine DMA model facing the page manager.
// ----------------------------------------------------------------------
module pbm_dma_model (
  // Clock.
  input wire logic mclk,
  // Answers from the manager.
  input wire logic allocation_done_interrupt_grant,
  input wire logic [4:0] allocation_done_interrupt_pkt,
  // Requests to the manager.
  output pbm_pkg::pbm_dma_s dma
);
  import pbm_pkg::*;

  // All requests idle at time zero.
  initial begin
    dma = '0;
  end

  // Holds a page request until the grant is sampled, or gives up.
  task automatic allocation_done_interrupt(input logic [3:0] pg, output logic [4:0] pkt,
                       output bit ok);
    int i;
    ok = 1'h0;
    pkt = 5'h00;
    @(posedge mclk);
    dma.allocation_done_interrupt_pages <= pg;
    dma.allocation_done_interrupt_req <= 1'h1;
    for (i = 0; i < 100 && !ok; i++) begin
      @(posedge mclk);
      if (allocation_done_interrupt_grant === 1'h1) begin
        ok = 1'h1;
        pkt = allocation_done_interrupt_pkt;
      end
    end
    dma.allocation_done_interrupt_req <= 1'h0;
    dma.allocation_done_interrupt_pages <= ~pg;
  endtask : allocation_done_interrupt

  // One request pulse: 0 receive, 1 transmit done, else page release.
  task automatic send(input int k, input logic [4:0] p, input logic [1:0] st);
    @(posedge mclk);
    case (k)
      0: begin
        dma.rx_pkt <= p;
        dma.rx_header_ok <= st[1];
        dma.rx_token_ok <= st[0];
        dma.rx_done <= 1'h1;
      end
      1: begin
        dma.tx_pkt <= p;
        dma.tx_done <= 1'h1;
      end
      default: begin
        dma.release_pkt <= p;
        dma.release_req <= 1'h1;
      end
    endcase
    @(posedge mclk);
    dma.rx_done <= 1'h0;
    dma.tx_done <= 1'h0;
    dma.release_req <= 1'h0;
    dma.rx_pkt <= ~p;
    dma.tx_pkt <= ~p;
    dma.release_pkt <= ~p;
    dma.rx_header_ok <= ~st[1];
    dma.rx_token_ok <= ~st[0];
  endtask : send

endmodule : pbm_dma_model

// >>> tb/testbench.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Self-checking bench for the packet buffer page manager.
// ----------------------------------------------------------------------
module testbench;
  import pbm_pkg::*;

  typedef struct {
    logic [15:0] a;
    logic w;
    logic [7:0] d;
    logic [7:0] e;
  } pbm_row_s;

  logic mclk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  pbm_dma_s dma;
  logic allocation_done_interrupt_grant, nak_receive, rx_overflow, allocation_done_interrupt_done;
  logic [4:0] allocation_done_interrupt_pkt, window_pkt, p;
  logic [4:0] pk [4];
  logic [7:0] q;
  logic e;
  bit ok;
  int n_fail, n_compared;
  logic [7:0] fr [4] = '{8'h16, 8'h0C, 8'h02, 8'h01};

  // Ordinary accesses: address, write, data, expected read.
  pbm_row_s rows [10] = '{
    '{IDX_FREE_PAGE_COUNT, 1'h0, 8'h00, 8'h20},
    '{IDX_TX_COMPLETION, 1'h0, 8'h00, 8'h80},
    '{IDX_RX_PACKET_QUEUE, 1'h0, 8'h00, 8'h80},
    '{IDX_PACKET_SELECTOR, 1'h1, 8'hF3, 8'h00},
    '{IDX_PACKET_SELECTOR, 1'h0, 8'h00, 8'h13},
    '{IDX_ENDPOINT_SELECT, 1'h1, 8'hFA, 8'h00},
    '{IDX_ENDPOINT_SELECT, 1'h0, 8'h00, 8'h0A},
    '{IDX_COMMAND, 1'h1, 8'h00, 8'h00},
    '{IDX_FREE_PAGE_COUNT, 1'h1, 8'hFF, 8'h00},
    '{IDX_FREE_PAGE_COUNT, 1'h0, 8'h00, 8'hA0}
  };

  pbm_manager i_dut (
    .MCLK(mclk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .DMA_IN(dma),
    .ALLOCATION_DONE_INTERRUPT_GRANT(allocation_done_interrupt_grant), .ALLOCATION_DONE_INTERRUPT_PKT(allocation_done_interrupt_pkt),
    .NAK_RECEIVE(nak_receive), .RX_OVERFLOW(rx_overflow),
    .WINDOW_PKT(window_pkt), .ALLOCATION_DONE_INTERRUPT_DONE(allocation_done_interrupt_done)
  );

  pbm_dma_model i_dma (
    .mclk(mclk), .allocation_done_interrupt_grant(allocation_done_interrupt_grant), .allocation_done_interrupt_pkt(allocation_done_interrupt_pkt),
    .dma(dma)
  );

  // ----------------------------------------------------------------------
  // Bus and checking tasks.
  // ----------------------------------------------------------------------
  task automatic results;
    if (n_fail == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [7:0] ex,
                     input logic [7:0] sn);
    n_compared++;
    if (sn !== ex) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, ex, sn);
    end
  endtask : chk

  // Setup cycle, then access held until pready is sampled high.
  task automatic apb(input logic [15:0] a, input logic w,
                     input logic [7:0] d, output logic [7:0] rq,
                     output logic re);
    int i;
    @(posedge mclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {a, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge mclk);
    penable <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(posedge mclk);
      if (pready === 1'h1) break;
    end
    rq = prdata[7:0];
    re = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (i == 50) begin
      n_fail++;
      results();
    end
  endtask : apb

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    apb(a, 1'h1, d, q, e);
  endtask : wr

  task automatic rd(input string nm, input logic [15:0] a,
                    input logic [7:0] ex, input logic [7:0] m = 8'hFF);
    apb(a, 1'h0, 8'h00, q, e);
    chk(nm, ex, q & m);
  endtask : rd

  // Watches a bounded window for the allocation-done pulse.
  task automatic wait_done(input logic ex);
    int i;
    logic seen;
    seen = 1'h0;
    for (i = 0; i < 20 && !seen; i++) begin
      @(posedge mclk);
      if (allocation_done_interrupt_done === 1'h1) seen = 1'h1;
    end
    chk("allocation_done_interrupt done", {7'h00, ex}, {7'h00, seen});
  endtask : wait_done

  // Free-running clock.
  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    int k;
    n_fail = 0;
    n_compared = 0;
    resetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 18'h00000;
    pwdata = 32'h00000000;
    repeat (16) @(posedge mclk);
    resetn <= 1'h1;
    for (k = 0; k < 10; k++) begin
      if (rows[k].w) wr(rows[k].a, rows[k].d);
      else rd($sformatf("row %0d", k), rows[k].a, rows[k].e);
    end
    chk("window", 8'h13, {3'h0, window_pkt});
    chk("nak on", 8'h01, {7'h00, nak_receive});
    i_dma.allocation_done_interrupt(4'h0, p, ok);
    chk("nak grant", 8'h00, {7'h00, ok});
    wr(IDX_FREE_PAGE_COUNT, 8'h00);
    repeat (2) @(posedge mclk);
    chk("nak off", 8'h00, {7'h00, nak_receive});
    // Oversized request is ignored.
    wr(IDX_COMMAND, 8'h2A);
    wait_done(1'h0);
    rd("free", IDX_FREE_PAGE_COUNT, 8'h20);
    // Each allocate waits for completion before the next one.
    for (k = 0; k < 4; k++) begin
      wr(IDX_COMMAND, (k < 3) ? 8'h29 : 8'h20);
      wait_done(1'h1);
      rd("result", IDX_ALLOCATION_DONE_INTERRUPT_RESULT, 8'h00, 8'h80);
      pk[k] = q[4:0];
      rd("free", IDX_FREE_PAGE_COUNT, fr[k]);
    end
    wr(IDX_COMMAND, 8'h22);
    wait_done(1'h0);
    rd("failed", IDX_ALLOCATION_DONE_INTERRUPT_RESULT, 8'h80, 8'h80);
    i_dma.send(2, pk[1], 2'h0);
    wait_done(1'h1);
    rd("result", IDX_ALLOCATION_DONE_INTERRUPT_RESULT, 8'h00, 8'h80);
    rd("free", IDX_FREE_PAGE_COUNT, 8'h08);
    wr(IDX_PACKET_SELECTOR, {3'h0, pk[0]});
    wr(IDX_COMMAND, 8'hA0);
    rd("free", IDX_FREE_PAGE_COUNT, 8'h12);
    wr(IDX_COMMAND, 8'h40);
    rd("free", IDX_FREE_PAGE_COUNT, 8'h20);
    // Receive queue: flawed packets skipped, head peeked then removed.
    i_dma.allocation_done_interrupt(4'h1, p, ok);
    chk("dma grant", 8'h01, {7'h00, ok});
    rd("free", IDX_FREE_PAGE_COUNT, 8'h1E);
    i_dma.send(0, p, 2'h3);
    i_dma.send(0, 5'h06, 2'h1);
    i_dma.send(0, 5'h07, 2'h2);
    i_dma.send(0, 5'h08, 2'h3);
    rd("rx head", IDX_RX_PACKET_QUEUE, {3'h0, p});
    rd("rx peek", IDX_RX_PACKET_QUEUE, {3'h0, p});
    wr(IDX_COMMAND, 8'h60);
    rd("rx next", IDX_RX_PACKET_QUEUE, 8'h08);
    rd("free", IDX_FREE_PAGE_COUNT, 8'h1E);
    i_dma.send(0, p, 2'h3);
    wr(IDX_COMMAND, 8'h60);
    wr(IDX_COMMAND, 8'h80);
    rd("free", IDX_FREE_PAGE_COUNT, 8'h20);
    rd("rx empty", IDX_RX_PACKET_QUEUE, 8'h80);
    // Fill both queues to their 32-entry limit.
    for (k = 0; k < 32; k++) i_dma.send(0, k[4:0], 2'h3);
    rd("rx full", IDX_RX_PACKET_QUEUE, 8'h40);
    chk("overflow", 8'h01, {7'h00, rx_overflow});
    for (k = 0; k < 32; k++) i_dma.send(1, 5'h1F - k[4:0], 2'h0);
    rd("cq full", IDX_TX_COMPLETION, 8'h5F);
    for (k = 1; k < 32; k++) begin
      rd("cq", IDX_TX_COMPLETION, 8'h1F - k[7:0]);
    end
    rd("cq empty", IDX_TX_COMPLETION, 8'h80);
    i_dma.send(1, 5'h09, 2'h0);
    wr(IDX_COMMAND, 8'h40);
    rd("rx reset", IDX_RX_PACKET_QUEUE, 8'h80);
    rd("cq reset", IDX_TX_COMPLETION, 8'h80);
    chk("overflow", 8'h00, {7'h00, rx_overflow});
    apb(16'h0100, 1'h0, 8'h00, q, e);
    chk("slave error", 8'h01, {7'h00, e});
    // Reset in mid-run with pages held.
    wr(IDX_COMMAND, 8'h24);
    wait_done(1'h1);
    wr(IDX_ENDPOINT_SELECT, 8'h03);
    wr(IDX_COMMAND, 8'hC0);
    wr(IDX_COMMAND, 8'hE0);
    rd("free", IDX_FREE_PAGE_COUNT, 8'h1B);
    @(posedge mclk);
    resetn <= 1'h0;
    repeat (3) @(posedge mclk);
    resetn <= 1'h1;
    rd("free", IDX_FREE_PAGE_COUNT, 8'h20);
    rd("cq", IDX_TX_COMPLETION, 8'h80);
    results();
  end

endmodule : testbench
